/* shared/sdf_pkg.sv */
// package: constants, register map and field layouts for the sinc decimation block
package sdf_pkg;
  // filter datapath width, wide enough for the largest sinc3 ratio
  localparam int unsigned DATA_W = 56;
  localparam int unsigned RATIO_W = 16;
  // sinc5 cascade: comb orders and per-section decimation (2*2*4*5 = 80)
  localparam int unsigned S1_ORDER = 3;
  localparam int unsigned S2_ORDER = 2;
  localparam int unsigned S3_ORDER = 3;
  localparam int unsigned S4_ORDER = 5;
  localparam int unsigned S3B_ORDER = 3;
  localparam logic [15:0] S1_RATIO = 16'h0002;
  localparam logic [15:0] S2_RATIO = 16'h0002;
  localparam logic [15:0] S3_RATIO = 16'h0004;
  localparam logic [15:0] S4_RATIO = 16'h0005;
  // highest rate code; code 0 is the bypass rate, code n gives D = 2**n up to it, codes above it give D = 512
  localparam logic [3:0] RATE_CODE_MAX = 4'h9;
  // sync sequence
  localparam logic [7:0] SYNC_FILL_BYTE = 8'hFF;
  localparam logic [7:0] SYNC_END_BYTE = 8'hFE;
  localparam logic [3:0] SYNC_FILL_COUNT = 4'hF;
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_DATA_LO = 8'h08;
  localparam logic [7:0] ADDR_DATA_HI = 8'h0C;
  localparam logic [7:0] ADDR_RATIO = 8'h10;
  // status bit positions
  localparam int unsigned ST_CMD_MODE = 0;
  localparam int unsigned ST_READY = 1;
  localparam int unsigned ST_BYPASS = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // control register layout, high bits first in the word
  typedef struct packed {
    logic sys_reset;          // bit 9, self clearing
    logic continuous;         // bit 8
    logic start;              // bit 7, self clearing
    logic [1:0] channel;      // bits 6:5
    logic reference_range_select; // bit 4
    logic [2:0] rate_code_hi; // bits 3:1, rate code over two
    logic rate_scale_select;  // bit 0
  } sdf_ctrl_s;
  localparam logic [9:0] CTRL_RESET = 10'h000;

  // one filter word on its way out
  typedef struct packed {
    logic valid;
    logic [1:0] channel;
    logic [DATA_W-1:0] data;
  } sdf_word_s;
endpackage

/* hdl/sdf_cic_sec.sv */
// one integrate/decimate/comb section of order N with runtime ratio
`timescale 1ns/10ps
`default_nettype none
module sdf_cic_sec #(
  parameter int unsigned N = 3
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic flush_i,
  // input words
  input wire logic in_valid_i,
  input wire logic [sdf_pkg::DATA_W-1:0] in_data_i,
  input wire logic [15:0] ratio_i,
  // decimated output
  output logic out_valid_o,
  output logic [sdf_pkg::DATA_W-1:0] out_data_o
);
  logic [sdf_pkg::DATA_W-1:0] integ_r [N];
  logic [sdf_pkg::DATA_W-1:0] comb_r [N];
  logic [sdf_pkg::DATA_W-1:0] diff [N];
  logic [15:0] cnt_r;
  logic take;

  assign take = in_valid_i && (cnt_r >= ratio_i - 16'h0001);

  // comb chain, differential delay of one output sample
  always_comb begin
    diff[0] = integ_r[N-1] - comb_r[0];
    for (int i = 1; i < N; i++) begin
      diff[i] = diff[i-1] - comb_r[i];
    end
  end

  // integrators run at the input rate; wrap-around is harmless in this structure
  always_ff @(posedge clock_i) begin
    if (!rstn_i || flush_i) begin
      for (int i = 0; i < N; i++) begin
        integ_r[i] <= '0;
      end
    end else if (in_valid_i) begin
      integ_r[0] <= integ_r[0] + in_data_i;
      for (int i = 1; i < N; i++) begin
        integ_r[i] <= integ_r[i] + integ_r[i-1];
      end
    end
  end

  // decimation counter: one output per ratio inputs
  always_ff @(posedge clock_i) begin
    if (!rstn_i || flush_i) begin
      cnt_r <= 16'h0000;
    end else if (take) begin
      cnt_r <= 16'h0000;
    end else if (in_valid_i) begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end

  // comb delay registers and output word
  always_ff @(posedge clock_i) begin
    if (!rstn_i || flush_i) begin
      for (int i = 0; i < N; i++) begin
        comb_r[i] <= '0;
      end
      out_valid_o <= 1'b0;
      out_data_o <= '0;
    end else begin
      out_valid_o <= take;
      if (take) begin
        comb_r[0] <= integ_r[N-1];
        for (int i = 1; i < N; i++) begin
          comb_r[i] <= diff[i-1];
        end
        out_data_o <= diff[N-1];
      end
    end
  end
endmodule
`default_nettype wire

/* hdl/sdf_top.sv */
// sinc5/sinc3 decimation chain, sync detector and AXI4-Lite register file
`timescale 1ns/10ps
`default_nettype none
module sdf_top (
  // clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // modulator bit stream, one enable per master-clock sample
  input wire logic mod_valid_i,
  input wire logic mod_bit_i,
  // bytes received by the serial port
  input wire logic port_byte_valid_i,
  input wire logic [7:0] port_byte_i,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // status to the serial port and analog front end
  output logic command_mode_o,
  output logic reference_range_select_o,
  output logic [1:0] channel_o,
  output logic word_valid_o,
  output logic [sdf_pkg::DATA_W-1:0] word_o
);
  sdf_pkg::sdf_ctrl_s ctrl_r;
  logic [1:0] last_chan_r;
  logic conv_on_r;
  logic ready_r;
  logic cmd_mode_r;
  logic [3:0] fill_cnt_r;
  logic flush_r;
  logic [3:0] rate_code;
  logic bypass;
  logic [15:0] d_ratio;
  logic [sdf_pkg::DATA_W-1:0] din;
  logic [4:0] sv;
  logic [sdf_pkg::DATA_W-1:0] sd [5];
  logic [sdf_pkg::DATA_W-1:0] word_r;
  logic [1:0] word_chan_r;
  sdf_pkg::sdf_word_s out_w;
  // AXI write state
  logic aw_held_r;
  logic w_held_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic do_write;
  logic start_pulse;

  assign rate_code = {ctrl_r.rate_code_hi, 1'b0};
  // code 0 is 3840 or 3200 words/s by the scale bit; sinc5 alone there
  assign bypass = (rate_code == 4'h0);
  // D = base/rate; both scale tables share the same ratios, a power of two
  assign d_ratio = (rate_code > sdf_pkg::RATE_CODE_MAX) ? 16'h0200
                 : (16'h0001 << rate_code);
  assign din = {{(sdf_pkg::DATA_W-1){1'b0}}, mod_bit_i};
  assign sv[0] = mod_valid_i;
  assign sd[0] = din;
  assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;
  assign start_pulse = do_write && (awaddr_r == sdf_pkg::ADDR_CTRL) && wstrb_r[0]
                     && wdata_r[7];

  // sinc5 cascade, 2 x 2 x 4 x 5 = 80 overall
  sdf_cic_sec #(.N(sdf_pkg::S1_ORDER)) u_s1 (
    .clock_i(clock_i), .rstn_i(rstn_i), .flush_i(flush_r),
    .in_valid_i(sv[0]), .in_data_i(sd[0]), .ratio_i(sdf_pkg::S1_RATIO),
    .out_valid_o(sv[1]), .out_data_o(sd[1]));
  sdf_cic_sec #(.N(sdf_pkg::S2_ORDER)) u_s2 (
    .clock_i(clock_i), .rstn_i(rstn_i), .flush_i(flush_r),
    .in_valid_i(sv[1]), .in_data_i(sd[1]), .ratio_i(sdf_pkg::S2_RATIO),
    .out_valid_o(sv[2]), .out_data_o(sd[2]));
  sdf_cic_sec #(.N(sdf_pkg::S3_ORDER)) u_s3 (
    .clock_i(clock_i), .rstn_i(rstn_i), .flush_i(flush_r),
    .in_valid_i(sv[2]), .in_data_i(sd[2]), .ratio_i(sdf_pkg::S3_RATIO),
    .out_valid_o(sv[3]), .out_data_o(sd[3]));
  sdf_cic_sec #(.N(sdf_pkg::S4_ORDER)) u_s4 (
    .clock_i(clock_i), .rstn_i(rstn_i), .flush_i(flush_r),
    .in_valid_i(sv[3]), .in_data_i(sd[3]), .ratio_i(sdf_pkg::S4_RATIO),
    .out_valid_o(sv[4]), .out_data_o(sd[4]));
  // sinc3 with programmable ratio, idle while bypassed
  sdf_cic_sec #(.N(sdf_pkg::S3B_ORDER)) u_s5 (
    .clock_i(clock_i), .rstn_i(rstn_i), .flush_i(flush_r),
    .in_valid_i(sv[4] && !bypass), .in_data_i(sd[4]), .ratio_i(d_ratio),
    .out_valid_o(out_w.valid), .out_data_o(out_w.data));

  assign out_w.channel = last_chan_r;

  // output word: sinc5 alone at the top rates, else sinc3; none while a flush is applied
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      word_valid_o <= 1'b0;
      word_r <= '0;
      word_chan_r <= 2'h0;
    end else begin
      word_valid_o <= conv_on_r && !flush_r && (bypass ? sv[4] : out_w.valid);
      if (conv_on_r && !flush_r && bypass && sv[4]) begin
        word_r <= sd[4];
        word_chan_r <= last_chan_r;
      end else if (conv_on_r && !flush_r && !bypass && out_w.valid) begin
        word_r <= out_w.data;
        word_chan_r <= out_w.channel;
      end
    end
  end
  assign word_o = word_r;

  // flush on system reset or on a start that moves to another channel
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      flush_r <= 1'b0;
      last_chan_r <= 2'h0;
    end else begin
      flush_r <= 1'b0;
      if (start_pulse) begin
        last_chan_r <= wdata_r[6:5];
        flush_r <= (wdata_r[6:5] != last_chan_r);
      end
      if (ctrl_r.sys_reset) begin
        flush_r <= 1'b1;
        last_chan_r <= 2'h0;
      end
    end
  end

  // conversion state: single stops after one word, continuous runs on
  always_ff @(posedge clock_i) begin
    if (!rstn_i || ctrl_r.sys_reset) begin
      conv_on_r <= 1'b0;
    end else if (start_pulse) begin
      conv_on_r <= 1'b1;
    end else if (word_valid_o && !ctrl_r.continuous) begin
      conv_on_r <= 1'b0;
    end
  end

  // sync detector: 15 fill bytes then the end byte give command mode
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      fill_cnt_r <= 4'h0;
      cmd_mode_r <= 1'b0;
    end else if (port_byte_valid_i) begin
      if (port_byte_i == sdf_pkg::SYNC_FILL_BYTE) begin
        if (fill_cnt_r != sdf_pkg::SYNC_FILL_COUNT) begin
          fill_cnt_r <= fill_cnt_r + 4'h1;
        end
      end else begin
        fill_cnt_r <= 4'h0;
        if (port_byte_i == sdf_pkg::SYNC_END_BYTE
            && fill_cnt_r == sdf_pkg::SYNC_FILL_COUNT) begin
          cmd_mode_r <= 1'b1;
        end else begin
          cmd_mode_r <= 1'b0;
        end
      end
    end
  end

  // control register; start and system reset clear themselves next cycle
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      ctrl_r <= sdf_pkg::CTRL_RESET;
    end else begin
      ctrl_r.start <= 1'b0;
      ctrl_r.sys_reset <= 1'b0;
      if (do_write && awaddr_r == sdf_pkg::ADDR_CTRL) begin
        if (wstrb_r[0]) begin
          ctrl_r.rate_scale_select <= wdata_r[0];
          ctrl_r.rate_code_hi <= wdata_r[3:1];
          ctrl_r.reference_range_select <= wdata_r[4];
          ctrl_r.channel <= wdata_r[6:5];
          ctrl_r.start <= wdata_r[7];
        end
        if (wstrb_r[1]) begin
          ctrl_r.continuous <= wdata_r[8];
          ctrl_r.sys_reset <= wdata_r[9];
        end
      end
    end
  end

  // data-ready flag: a new word wins over a clearing write
  always_ff @(posedge clock_i) begin
    if (!rstn_i || ctrl_r.sys_reset) begin
      ready_r <= 1'b0;
    end else if (word_valid_o) begin
      ready_r <= 1'b1;
    end else if (do_write && awaddr_r == sdf_pkg::ADDR_STATUS && wstrb_r[0]
                 && wdata_r[sdf_pkg::ST_READY]) begin
      ready_r <= 1'b0;
    end
  end

  // write channel: either order, then response; readies registered from the next state
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= sdf_pkg::RESP_OKAY;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r <= {s_axi_awaddr[7:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_r <= sdf_pkg::ADDR_STATUS) ? sdf_pkg::RESP_OKAY
                     : sdf_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_awready <= !do_write && !aw_held_r && !(s_axi_awvalid && s_axi_awready)
                       && !(s_axi_bvalid && !s_axi_bready);
      s_axi_wready <= !do_write && !w_held_r && !(s_axi_wvalid && s_axi_wready)
                      && !(s_axi_bvalid && !s_axi_bready);
    end
  end

  // read channel: one cycle from address to data
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= sdf_pkg::RESP_OKAY;
      s_axi_arready <= 1'b1;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_arready <= 1'b0;
      s_axi_rresp <= sdf_pkg::RESP_OKAY;
      if (s_axi_araddr[7:2] == sdf_pkg::ADDR_CTRL[7:2]) begin
        s_axi_rdata <= {23'h00000, ctrl_r[8:0] & 9'h17F};
      end else if (s_axi_araddr[7:2] == sdf_pkg::ADDR_STATUS[7:2]) begin
        s_axi_rdata <= {29'h00000000, bypass, ready_r, cmd_mode_r};
      end else if (s_axi_araddr[7:2] == sdf_pkg::ADDR_DATA_LO[7:2]) begin
        s_axi_rdata <= word_r[31:0];
      end else if (s_axi_araddr[7:2] == sdf_pkg::ADDR_DATA_HI[7:2]) begin
        s_axi_rdata <= {6'h00, word_chan_r, word_r[sdf_pkg::DATA_W-1:32]};
      end else if (s_axi_araddr[7:2] == sdf_pkg::ADDR_RATIO[7:2]) begin
        s_axi_rdata <= {16'h0000, d_ratio};
      end else begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= sdf_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // status pins
  assign command_mode_o = cmd_mode_r;
  assign reference_range_select_o = ctrl_r.reference_range_select;
  assign channel_o = last_chan_r;
endmodule
`default_nettype wire

/* dv/sdf_sva.sv */
// checker bound to the decimation block ports
`timescale 1ns/10ps
`default_nettype none
module sdf_sva (
  // clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // stream and port bytes
  input wire logic mod_valid_i,
  input wire logic port_byte_valid_i,
  input wire logic [7:0] port_byte_i,
  // register bus
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // watched outputs
  input wire logic command_mode_o,
  input wire logic word_valid_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  logic [7:0] ns_r;
  logic [3:0] nf_r;
  // samples since last word, saturating so long idles cannot wrap
  always_ff @(posedge clock_i) begin
    if (!rstn_i || word_valid_o) ns_r <= 8'h00;
    else if (mod_valid_i && ns_r != 8'hFF) ns_r <= ns_r + 8'h01;
  end
  // run of fill bytes seen on the port
  always_ff @(posedge clock_i) begin
    if (!rstn_i) nf_r <= 4'h0;
    else if (port_byte_valid_i && port_byte_i != 8'hFF) nf_r <= 4'h0;
    else if (port_byte_valid_i && nf_r != 4'hF) nf_r <= nf_r + 4'h1;
  end
  a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped early");
  a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped early");
  a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted during response");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted during response");
  a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr >= 8'h14
    |=> s_axi_rvalid && s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read answer wrong");
  a_word_spacing: assert property (word_valid_o |-> ns_r >= 8'd79)
    else $error("words closer than one sinc5 frame");
  a_sync_enter: assert property (port_byte_valid_i && port_byte_i == 8'hFE
    && nf_r == 4'hF |=> command_mode_o) else $error("sync did not enter command mode");
  a_sync_leave: assert property (port_byte_valid_i && port_byte_i != 8'hFF
    && port_byte_i != 8'hFE |=> !command_mode_o) else $error("command mode kept");
endmodule
bind sdf_top sdf_sva chk (
  .clock_i(clock_i),
  .rstn_i(rstn_i),
  .mod_valid_i(mod_valid_i),
  .port_byte_valid_i(port_byte_valid_i),
  .port_byte_i(port_byte_i),
  .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .command_mode_o(command_mode_o),
  .word_valid_o(word_valid_o)
);
`default_nettype wire

/* dv/sdf_host.sv */
// host model: modulator sample stream and serial-port bytes
`timescale 1ns/10ps
`default_nettype none
module sdf_host (
  // clock
  input wire logic clock_i,
  // sample stream
  output logic mod_valid_o,
  output logic mod_bit_o,
  // port bytes
  output logic byte_valid_o,
  output logic [7:0] byte_o
);
  int per = 2;
  int cnt = 0;
  initial begin
    mod_valid_o = 1'b0;
    mod_bit_o = 1'b0;
    byte_valid_o = 1'b0;
    byte_o = 8'h00;
  end
  // enable every per cycles stands for the master clock rate
  always @(posedge clock_i) begin
    cnt <= (cnt >= per - 1) ? 0 : cnt + 1;
    mod_valid_o <= (cnt == 0);
    mod_bit_o <= (cnt == 0) ? 1'($urandom) : ~mod_bit_o;
  end
  // idle line shows the inverse so a stale byte cannot match
  task automatic send(input logic [7:0] b);
    @(posedge clock_i);
    byte_valid_o <= 1'b1;
    byte_o <= b;
    @(posedge clock_i);
    byte_valid_o <= 1'b0;
    byte_o <= ~b;
  endtask
endmodule
`default_nettype wire

/* dv/tb.sv */
// self-checking bench for the decimation block
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clock_i = 1'b0;
  logic rstn_i = 1'b0;
  logic mv, mb, pbv, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic [7:0] pb, awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rd, v;
  logic awr, wr, bv, arr, rv, cmd, rsel, wvld;
  logic [1:0] br, rr, chan, r;
  logic [sdf_pkg::DATA_W-1:0] word;
  int n_fail = 0, compares = 0, cyc = 0, t0, ch, lag = 0;
  always #5 clock_i = ~clock_i;
  sdf_host host (.clock_i(clock_i), .mod_valid_o(mv), .mod_bit_o(mb),
    .byte_valid_o(pbv), .byte_o(pb));
  sdf_top dut (.clock_i(clock_i), .rstn_i(rstn_i), .mod_valid_i(mv), .mod_bit_i(mb),
    .port_byte_valid_i(pbv), .port_byte_i(pb), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .command_mode_o(cmd),
    .reference_range_select_o(rsel), .channel_o(chan), .word_valid_o(wvld), .word_o(word));
  task automatic results();
    if (n_fail == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // cycle count doubles as hang guard
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail++;
      results();
    end
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [31:0] d_exp(input int k);
    return (k == 0) ? 32'h1 : (2 * k > 9) ? 32'h200 : 32'h1 << (2 * k);
  endfunction
  // handshakes judged at the falling edge, acted on at the next rising edge
  // lag set before a call holds bready or rready low for that many cycles
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_hs, w_hs, b_hs;
    int n;
    n = lag;
    lag = 0;
    @(posedge clock_i);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= (n == 0);
    b_hs = 1'b0;
    while (!b_hs) begin
      @(negedge clock_i);
      aw_hs = awv && awr;
      w_hs = wv && wr;
      b_hs = (bv === 1'b1) && bry;
      r = br;
      @(posedge clock_i);
      if (aw_hs) awv <= 1'b0;
      if (w_hs) wv <= 1'b0;
      if (b_hs) begin
        bry <= 1'b0;
      end else if (n > 0) begin
        n--;
        bry <= (n == 0);
      end
    end
  endtask
  task automatic axi_rd(input logic [7:0] a);
    logic ar_hs, r_hs;
    int n;
    n = lag;
    lag = 0;
    @(posedge clock_i);
    ara <= a;
    arv <= 1'b1;
    rry <= (n == 0);
    r_hs = 1'b0;
    while (!r_hs) begin
      @(negedge clock_i);
      ar_hs = arv && arr;
      r_hs = (rv === 1'b1) && rry;
      v = rd;
      r = rr;
      @(posedge clock_i);
      if (ar_hs) arv <= 1'b0;
      if (r_hs) begin
        rry <= 1'b0;
      end else if (n > 0) begin
        n--;
        rry <= (n == 0);
      end
    end
  endtask
  task automatic sync(input int n);
    repeat (n) host.send(sdf_pkg::SYNC_FILL_BYTE);
    host.send(sdf_pkg::SYNC_END_BYTE);
    repeat (3) @(posedge clock_i);
  endtask
  task automatic wait_word();
    do @(negedge clock_i); while (wvld !== 1'b1);
  endtask
  // continuous run on default calibration, spacing of two settled words
  task automatic conv(input int k, input int c, input int per);
    host.per = per;
    axi_wr(8'h00, 32'h180 | (c << 5) | (k << 1));
    wait_word();
    wait_word();
    t0 = cyc;
    wait_word();
    check("spacing", cyc - t0, 80 * per * d_exp(k));
    check("channel", chan, c);
    axi_rd(8'h0C);
    check("data channel", v[25:24], c);
    axi_rd(8'h04);
    check("ready", v[1], 1'b1);
    // stop between words: single mode still lets the word under way out
    wait_word();
    axi_wr(8'h00, c << 5);
    wait_word();
    t0 = 0;
    repeat (80 * per * d_exp(k) + 20) begin
      @(negedge clock_i);
      if (wvld !== 1'b0) t0++;
    end
    check("idle words", t0, 0);
  endtask
  initial begin
    void'($urandom(32'hDA47));
    repeat (3) @(posedge clock_i);
    rstn_i <= 1'b1;
    repeat (20) @(posedge clock_i);
    axi_rd(8'h00);
    check("ctrl reset", v, 32'h0);
    axi_rd(8'h04);
    check("status reset", v[2:0], 3'h4);
    axi_rd(8'h20);
    check("unmapped rd", {r, v[29:0]}, {sdf_pkg::RESP_SLVERR, 30'h0});
    lag = 2;
    axi_wr(8'h08, 32'h5);
    check("ro wr", r, sdf_pkg::RESP_SLVERR);
    axi_wr(8'h24, 32'h5);
    check("unmapped wr", r, sdf_pkg::RESP_SLVERR);
    // one fill short, then full sequence from a stray byte
    sync(14);
    check("short sync", cmd, 1'b0);
    host.send(8'($urandom_range(253, 0)));
    sync(15);
    check("sync", cmd, 1'b1);
    lag = 3;
    axi_rd(8'h04);
    check("status cmd", v[0], 1'b1);
    host.send(8'h12);
    repeat (3) @(posedge clock_i);
    check("leave cmd", cmd, 1'b0);
    sync(15);
    check("resync", cmd, 1'b1);
    axi_wr(8'h00, 32'hE0);
    check("chan set", chan, 2'h3);
    axi_wr(8'h00, 32'h200);
    @(negedge clock_i);
    check("sys reset", chan, 2'h0);
    axi_wr(8'h00, 32'h10);
    check("ref range", rsel, 1'b1);
    axi_rd(8'h00);
    check("ctrl rd", v, 32'h10);
    for (int k = 0; k < 6; k++) begin
      axi_wr(8'h00, (k << 1) | (1 & $urandom));
      check("ctrl resp", r, sdf_pkg::RESP_OKAY);
      axi_rd(8'h04);
      check("bypass", v[2], k == 0);
      axi_rd(8'h10);
      if (k != 0) check("ratio", v, d_exp(k));
    end
    ch = $urandom_range(3, 0);
    conv(0, ch, 2);
    conv(0, ch, 3);
    conv(1, (ch + 1) % 4, 2);
    results();
  end
endmodule
`default_nettype wire
